// ==== rtl/boot_ctl_consts.vh ====
/*
  constants for the boot overlay and clock control block.
  assumes a 10 MHz core_clk; included by its bare name.
*/
`ifndef BOOT_CTL_CONSTS_VH
`define BOOT_CTL_CONSTS_VH
`define CORE_CLK_HZ          10000000
`define RESET_PULSE_US       100
`define RESET_PULSE_CYCLES   ((`RESET_PULSE_US * (`CORE_CLK_HZ / 1000000)))
`define CPU_DIV_FULL         4
`define CPU_DIV_PRESCALE     16
`define RESET_CNT_W          11
`define DIV_CNT_W            4
`define HOST_WIN_BASE        16'hFEF8
`define HOST_WIN_MASK        16'hFFF8
`define RESET_LAST           11'h3E7
`define PRE_LAST             4'hF
`define RESET_CNT_RST        11'h000
`define PRE_CNT_RST          4'h0
`define DIV_CNT_RST          2'h0
`define ADDR_BIT_RST         1'b0
`define RNW_RST              1'b1
`define VALID_RST            1'b0
`define CPU_CLK_RST          1'b0
`define RESET_N_RST          1'b0
`define BOOT_RST             1'b1
`define ROM_LOCK_RST         1'b0
`define ROM_SEL_N_RST        1'b0
`define CAS_EN_RST           1'b0
`define WIN_SEL_RST          1'b0
`endif

// ==== rtl/boot_overlay_clock_control.v ====
/*
  boot overlay and processor clock control: power-up reset pulse, boot flag,
  slowed clock in boot mode, rom/ram steering, host window decode.
  assumes core_clk stands in for the crystal, and cpu-side inputs arrive
  asynchronously to it, so they pass two flip-flops before use.
*/
// What this block does
// - processor clock derived from core clock by dividers
// - full-speed processor clock is core divided by four
// - power-up drives reset low, sets boot flag
// - boot flag enables prescaler, rom select, steering
// - boot mode clock runs one sixteenth speed
// - processor starts fetching from rom after reset
// - boot reads suppress column strobe, writes keep it
// - host window access clears boot flag
// - cleared flag deselects rom, full-speed clock
// - outside boot all addresses except the host window map to dram
// - rom never selected again after boot
`timescale 1ns/10ps
`include "boot_ctl_consts.vh"

module boot_overlay_clock_control (
  input  wire        core_clk,
  input  wire        srst,
  input  wire [15:0] cpu_addr,
  input  wire        cpu_rnw,
  input  wire        cpu_valid,
  output reg         cpu_clock_in,
  output reg         cpu_reset_n,
  output reg         boot_mode,
  output reg         rom_sel_n,
  output reg         dram_cas_en,
  output reg         host_win_sel
);

  // two-stage synchronisers for the cpu-side pins
  reg  [15:0]             addr_s1_reg;
  reg  [15:0]             addr_s2_reg;
  reg                     rnw_s1_reg;
  reg                     rnw_s2_reg;
  reg                     valid_s1_reg;
  reg                     valid_s2_reg;

  // reset pulse counter and next values of the flag outputs
  reg  [`RESET_CNT_W-1:0] rst_cnt_reg;
  reg  [`RESET_CNT_W-1:0] rst_cnt_next;
  reg                     cpu_reset_n_next;
  reg                     boot_mode_next;

  // prescaler and divide-by-four stage
  reg  [`DIV_CNT_W-1:0]   pre_cnt_reg;
  reg  [`DIV_CNT_W-1:0]   pre_cnt_next;
  reg  [1:0]              div_cnt_reg;
  reg  [1:0]              div_cnt_next;
  reg                     cpu_clock_next;

  // steering next values and the rom lock
  reg                     rom_lock_reg;
  reg                     rom_lock_next;
  reg                     rom_sel_n_next;
  reg                     dram_cas_next;
  reg                     host_win_next;

  // decode and enables
  wire                    pre_tick;
  wire                    div_en;
  wire                    win_match;
  wire                    win_hit;
  wire                    reset_done;

  // limitation: the address must settle before valid rises;
  // bits are synchronised one by one and could skew otherwise
  genvar                  bit_idx;
  generate
    for (bit_idx = 0; bit_idx < 16; bit_idx = bit_idx + 1) begin : addr_sync
      always @(posedge core_clk) begin
        if (srst) begin
          addr_s1_reg[bit_idx] <= `ADDR_BIT_RST;
          addr_s2_reg[bit_idx] <= `ADDR_BIT_RST;
        end else begin
          addr_s1_reg[bit_idx] <= cpu_addr[bit_idx];
          addr_s2_reg[bit_idx] <= addr_s1_reg[bit_idx];
        end
      end
    end
  endgenerate

  // read/write pin, two flops
  always @(posedge core_clk) begin
    if (srst) begin
      rnw_s1_reg <= `RNW_RST;
    end else begin
      rnw_s1_reg <= cpu_rnw;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      rnw_s2_reg <= `RNW_RST;
    end else begin
      rnw_s2_reg <= rnw_s1_reg;
    end
  end

  // valid pin, two flops; same latency as the address
  always @(posedge core_clk) begin
    if (srst) begin
      valid_s1_reg <= `VALID_RST;
    end else begin
      valid_s1_reg <= cpu_valid;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      valid_s2_reg <= `VALID_RST;
    end else begin
      valid_s2_reg <= valid_s1_reg;
    end
  end

  // host window decode on the synchronised address
  assign win_match  = ((addr_s2_reg & `HOST_WIN_MASK) == `HOST_WIN_BASE);
  assign win_hit    = valid_s2_reg && win_match;
  // counter parks at its last value once the pulse is over
  assign reset_done = (rst_cnt_reg == `RESET_LAST);

  // prescaler wraps once per sixteen core clocks
  assign pre_tick = (pre_cnt_reg == `PRE_LAST);
  // outside boot the divider steps on every clock
  assign div_en   = boot_mode ? pre_tick : 1'b1;

  // power-up pulse length count
  always @* begin
    rst_cnt_next = rst_cnt_reg;
    if (!reset_done) begin
      rst_cnt_next = rst_cnt_reg + 1'b1;
    end
  end

  always @* begin
    cpu_reset_n_next = cpu_reset_n;
    if (reset_done) begin
      cpu_reset_n_next = 1'b1;
    end
  end

  // only srst sets the flag, so boot is never re-entered
  always @* begin
    boot_mode_next = boot_mode;
    if (cpu_reset_n && win_hit) begin
      boot_mode_next = 1'b0;
    end
  end

  // counter, reset and flag registers
  always @(posedge core_clk) begin
    if (srst) begin
      rst_cnt_reg <= `RESET_CNT_RST;
    end else begin
      rst_cnt_reg <= rst_cnt_next;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      cpu_reset_n <= `RESET_N_RST;
    end else begin
      cpu_reset_n <= cpu_reset_n_next;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      boot_mode <= `BOOT_RST;
    end else begin
      boot_mode <= boot_mode_next;
    end
  end

  // prescaler held at zero outside boot, saving its toggles
  always @* begin
    pre_cnt_next = `PRE_CNT_RST;
    if (boot_mode && !pre_tick) begin
      pre_cnt_next = pre_cnt_reg + 1'b1;
    end
  end

  // divide-by-four stage; its top bit is the processor clock
  always @* begin
    div_cnt_next   = div_cnt_reg;
    cpu_clock_next = cpu_clock_in;
    if (div_en) begin
      div_cnt_next   = div_cnt_reg + 1'b1;
      cpu_clock_next = div_cnt_reg[1];
    end
  end

  // divider registers
  always @(posedge core_clk) begin
    if (srst) begin
      pre_cnt_reg <= `PRE_CNT_RST;
    end else begin
      pre_cnt_reg <= pre_cnt_next;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      div_cnt_reg <= `DIV_CNT_RST;
    end else begin
      div_cnt_reg <= div_cnt_next;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      cpu_clock_in <= `CPU_CLK_RST;
    end else begin
      cpu_clock_in <= cpu_clock_next;
    end
  end

  // second guard on the rom: once boot ends, only srst unlocks it
  always @* begin
    rom_lock_next = rom_lock_reg;
    if (!boot_mode) begin
      rom_lock_next = 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      rom_lock_reg <= `ROM_LOCK_RST;
    end else begin
      rom_lock_reg <= rom_lock_next;
    end
  end

  // rom select follows the flag one clock later
  always @* begin
    rom_sel_n_next = 1'b1;
    if (boot_mode && !rom_lock_reg) begin
      rom_sel_n_next = 1'b0;
    end
  end

  // boot: reads come from rom, writes land in ram
  // after boot: every address is dram except the window
  always @* begin
    dram_cas_next = !win_hit;
    if (boot_mode) begin
      dram_cas_next = !rnw_s2_reg;
    end
  end

  // window select is a plain registered decode
  always @* begin
    host_win_next = win_hit;
  end

  // steering registers
  always @(posedge core_clk) begin
    if (srst) begin
      rom_sel_n <= `ROM_SEL_N_RST;
    end else begin
      rom_sel_n <= rom_sel_n_next;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      dram_cas_en <= `CAS_EN_RST;
    end else begin
      dram_cas_en <= dram_cas_next;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      host_win_sel <= `WIN_SEL_RST;
    end else begin
      host_win_sel <= host_win_next;
    end
  end

endmodule // boot_overlay_clock_control

// ==== verification/boot_ctl_chk_assertions.sv ====
/* checker for the boot overlay block; sees only its ports, bound below */
`timescale 1ns/10ps
module boot_ctl_chk(input wire core_clk, input wire srst, input wire [15:0] cpu_addr, input wire cpu_rnw,
  input wire cpu_valid, input wire cpu_clock_in, input wire cpu_reset_n, input wire boot_mode,
  input wire rom_sel_n, input wire dram_cas_en, input wire host_win_sel);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  wire hit = cpu_valid && (cpu_addr & 16'hFFF8) == 16'hFEF8;
  flag_sticky_a: assert property (!boot_mode |=> !boot_mode) else $error("boot re-set");
  rom_off_a: assert property (!boot_mode && !$past(boot_mode) |-> rom_sel_n) else $error("rom on");
  reset_boot_a: assert property (!cpu_reset_n |-> boot_mode && !rom_sel_n) else $error("no boot");
  win_clear_a: assert property (cpu_reset_n && hit |-> ##3 !boot_mode) else $error("no clear");
  win_sel_a: assert property ($past(cpu_reset_n & hit, 3) |-> host_win_sel) else $error("no sel");
  boot_read_a: assert property (boot_mode && $past(cpu_valid & cpu_rnw, 3) |-> !dram_cas_en) else $error("rd");
  boot_write_a: assert property (boot_mode && $past(cpu_valid & !cpu_rnw, 3) |-> dram_cas_en) else $error("wr");
  full_speed_a: assert property ($rose(cpu_clock_in) && !boot_mode && !$past(boot_mode, 8)
    |-> ##4 $rose(cpu_clock_in)) else $error("not div4");
  slow_clock_a: assert property ($rose(cpu_clock_in) && boot_mode ##64 boot_mode
    |-> $rose(cpu_clock_in)) else $error("not div16");
endmodule // boot_ctl_chk
bind boot_overlay_clock_control boot_ctl_chk boot_ctl_chk_inst(.*);

// ==== verification/cpu_model.sv ====
/* processor-side model; idle bus shows the inverse of the request */
`timescale 1ns/10ps
module cpu_model(input wire cpu_reset_n, input wire [15:0] req_addr, input wire req_rnw, input wire req_valid,
  output wire [15:0] cpu_addr, output wire cpu_rnw, output wire cpu_valid);
  assign cpu_valid = cpu_reset_n & req_valid;
  assign cpu_addr  = cpu_valid ? req_addr : ~req_addr;
  assign cpu_rnw   = cpu_valid ? req_rnw : ~req_rnw;
endmodule // cpu_model

// ==== verification/boot_overlay_clock_control_tb.sv ====
/* bench for the boot overlay block; cpu_model stands on the far side */
`timescale 1ns/10ps
`include "boot_ctl_consts.vh"
module boot_overlay_clock_control_tb;
  reg core_clk = 0, srst = 1, req_valid = 0, req_rnw = 1;
  reg [15:0] req_addr = 16'h0000;
  reg [31:0] seed = 32'hF862EDF7;
  integer num_errors = 0, num_checks = 0, cyc = 0, i, per;
  wire [15:0] cpu_addr;
  wire cpu_rnw, cpu_valid, cpu_clock_in, cpu_reset_n, boot_mode, rom_sel_n, dram_cas_en, host_win_sel;
  always #50 core_clk = ~core_clk;
  boot_overlay_clock_control boot_overlay_clock_control_inst(.*);
  cpu_model cpu_model_inst(.*);
  function [31:0] xs(input [31:0] s); reg [31:0] t; begin t = s ^ (s << 13); t = t ^ (t >> 17);
    xs = t ^ (t << 5); end endfunction
  function is_win(input [15:0] a); is_win = (a & 16'hFFF8) == 16'hFEF8; endfunction
  task check(input [15:0] seen, input [15:0] exp); begin num_checks = num_checks + 1;
    if (seen !== exp) begin num_errors = num_errors + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp); end end endtask
  task wrap_up; begin if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL"); $finish; end endtask
  task drive(input [15:0] a, input r); begin @(posedge core_clk); #1 req_addr = a; req_rnw = r; req_valid = 1;
    end endtask
  // core clocks between two rises of the processor clock
  task period(output integer n); reg prev; begin prev = cpu_clock_in;
    while (!(cpu_clock_in && !prev)) begin prev = cpu_clock_in; @(posedge core_clk); #1; end
    n = 0;
    prev = 1'b1;
    while (!(cpu_clock_in && !prev)) begin prev = cpu_clock_in; @(posedge core_clk); #1; n = n + 1; end
    end endtask
  // budget covers the 1000-cycle pulse plus traffic
  always @(posedge core_clk) begin cyc = cyc + 1; if (cyc == 9000) begin num_errors = num_errors + 1; wrap_up; end end
  initial begin
    repeat (6) @(posedge core_clk); #1 srst = 0;
    i = 0; while (cpu_reset_n !== 1'b1 && i < 2000) begin @(posedge core_clk); #1 i = i + 1; end
    check(i[15:0], `RESET_PULSE_CYCLES);
    period(per);
    check(per[15:0], `CPU_DIV_FULL * `CPU_DIV_PRESCALE);
    // bit 8 set keeps boot traffic off the window
    for (i = 0; i < 300; i = i + 1) begin seed = xs(seed);
      drive(seed[15:0] | 16'h0100, seed[16]); repeat (3) @(posedge core_clk); #1;
      check(dram_cas_en, !req_rnw);
      check(host_win_sel, 0);
    end
    check(boot_mode, 1);
    check(rom_sel_n, 0);
    drive({13'h1FDF, seed[2:0]}, seed[3]); repeat (5) @(posedge core_clk); #1;
    check(boot_mode, 0);
    check(rom_sel_n, 1);
    period(per);
    check(per[15:0], `CPU_DIV_FULL);
    for (i = 0; i < 200; i = i + 1) begin seed = xs(seed);
      drive(seed[20] ? {13'h1FDF, seed[2:0]} : seed[15:0], seed[16]); repeat (3) @(posedge core_clk); #1;
      check(dram_cas_en, !is_win(req_addr));
      check(host_win_sel, is_win(req_addr));
      check(rom_sel_n, 1);
      check(boot_mode, 0); end
    wrap_up;
  end
endmodule // boot_overlay_clock_control_tb
